// *** design/asc_pkg.sv ***
package asc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register file.
	localparam int              REG_COUNT       = 10;
	localparam logic [3:0]      REG_LAST_ADDR   = 4'h9;
	localparam logic [3:0]      REG_CFG0_ADDR   = 4'h0;
	localparam int              CFG0_STAT_BIT   = 1;
	localparam int              CFG0_IDLE_SEL_BIT = 6;
	// The identification value in the top entry is arbitrary.
	localparam logic [REG_COUNT-1:0][7:0] REG_DEFAULT = {
		8'h5a, 8'h00, 8'h00, 8'h00, 8'hff,
		8'hff, 8'h00, 8'h00, 8'h83, 8'h0a
	};
	localparam logic [REG_COUNT-1:0][7:0] REG_WMASK = {
		8'h00, 8'hff, 8'hff, 8'h3d, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h7e
	};

	////////////////////////////////////////////////////////////////////////
	// Command byte.
	localparam logic [2:0]      CMD_CH_READ     = 3'h1;
	localparam logic [2:0]      CMD_REG_READ    = 3'h2;
	localparam logic [2:0]      CMD_REG_WRITE   = 3'h3;
	localparam logic [2:0]      CMD_PULSE       = 3'h4;
	localparam logic [2:0]      CMD_RESET       = 3'h6;
	localparam logic [2:0]      DIRECT_LOW      = 3'h0;
	localparam logic [2:0]      DIRECT_HIGH     = 3'h7;
	localparam int              CMD_MULTI_BIT   = 4;
	localparam logic [2:0]      DIRECT_BIT_IDX  = 3'h2;
	localparam logic [2:0]      BYTE_LAST_BIT   = 3'h7;
	localparam logic [1:0]      CH_BYTE_LAST    = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Idle clock timeout, in master clock cycles.
	localparam logic [12:0]     TIMEOUT_LONG_CYC  = 13'h1000;
	localparam logic [12:0]     TIMEOUT_SHORT_CYC = 13'h0100;

	////////////////////////////////////////////////////////////////////////
	// Result codes.
	localparam logic [23:0]     FS_POS          = 24'h7fffff;
	localparam logic [23:0]     FS_NEG          = 24'h800000;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_DIRECT,
		ST_CH_READ,
		ST_REG_READ,
		ST_REG_WRITE
	} asc_link_state_t;

endpackage : asc_pkg

// *** design/asc_serial_port.sv ***
// Notes on behaviour
// R1 - Input sampled on rising serial clock, output changes on falling edge.
// R2 - Output released to high impedance whenever chip select is high.
// R3 - On a shared bus the host uses only the command-format result read.
// R4 - First three bits all zero or all one start a direct result read.
// R5 - After a direct read, commands ignored until select, timeout or reset.
// R6 - Direct read shows its first bit before the first clock edge.
// R7 - Direct read is 24 transitions, or 32 with the status byte enabled.
// R8 - Host finishes a direct read before the next ready strobe.
// R9 - A second direct read in the same ready interval returns zero data.
// R10 - Command-format read uses code 001 with multi access set.
// R11 - Command read restarts result MSB at eighth falling edge, 40 transitions.
// R12 - Command-format read is never corrupted by a result update.
// R13 - Register read shifts addressed register out from the eighth falling edge.
// R14 - Register write captures the data byte from the ninth rising edge.
// R15 - Multi access walks successive addresses and ends after address nine.
// R16 - Reset command returns every register to its default value.
// R17 - Host clears a locked interface before sending the reset command.
// R18 - Interface recovers by reset pin, select toggle or idle clock.
// R19 - Status enable selects four-byte or three-byte direct result reads.
// R20 - Status byte: fresh, overrange, supply low, channel tag, then data.
// R21 - Fresh flag set on a new result, cleared when that result is read.
// R22 - Overrange clips the code to full scale of the input's sign.
// R23 - Supply-low flag follows the analog supply monitor.
// R24 - Idle clock for 4096 or 256 master clocks resets the interface.
// R25 - Chip select high aborts transfers; ready strobe ignores chip select.
// R26 - Codes 100 and 110 are pulse convert and reset; other fields ignored.
// R27 - Result is two's complement, most significant bit first.
// R28 - Reserved code completes its byte and does nothing else.
module asc_serial_port
	import asc_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        result_valid_i,
	input  wire logic [23:0] result_data_i,
	input  wire logic        result_overrange_i,
	input  wire logic [4:0]  channel_tag_i,
	input  wire logic        supply_low_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        din_i,
	output logic             dout_o,
	output logic             dout_oe_o,
	output logic             result_ready_n_o,
	output logic             pulse_convert_o,
	output logic             reset_cmd_o,
	output logic             idle_timeout_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic                         rst_link_r;
	logic                         sclk_s1_r;
	logic                         sclk_s2_r;
	logic                         sclk_s3_r;
	logic                         sel_s1_r;
	logic                         sel_s2_r;
	logic [12:0]                  idle_cnt_r;
	logic [12:0]                  idle_limit;
	logic                         sclk_edge;
	logic                         abort_r;
	logic                         link_clr;
	logic [3:0]                   ev_tog_r;
	logic [3:0]                   ev_s1_r;
	logic [3:0]                   ev_s2_r;
	logic [3:0]                   ev_s3_r;
	logic [3:0]                   ev_pulse;
	logic                         busy_r;
	logic                         busy_s1_r;
	logic                         busy_s2_r;
	logic [23:0]                  pend_data_r;
	logic [6:0]                   pend_flags_r;
	logic                         pend_v_r;
	logic [23:0]                  hold_data_r;
	logic [6:0]                   hold_flags_r;
	logic                         fresh_r;
	logic                         taken_r;
	logic                         xfer;
	logic                         xfer_d_r;
	logic                         ready_n_r;
	logic                         pulse_r;
	logic                         rstcmd_r;
	logic [23:0]                  clip_data;
	asc_link_state_t              state_r;
	logic [2:0]                   bit_cnt_r;
	logic [6:0]                   rx_sr_r;
	logic [7:0]                   rx_byte;
	logic                         multi_r;
	logic [3:0]                   ptr_r;
	logic [1:0]                   ch_byte_r;
	logic [REG_COUNT-1:0][7:0]    regs_r;
	logic                         direct_hit;
	logic                         cmd_done;
	logic                         op_end;
	logic                         ptr_ok;
	logic                         started_r;
	logic [2:0]                   fbit_r;
	logic [31:0]                  tx_sr_r;
	logic [7:0]                   status_byte;
	logic [23:0]                  direct_data;
	logic [31:0]                  direct_word;
	logic [31:0]                  ch_word;
	logic [7:0]                   rd_byte;

	////////////////////////////////////////////////////////////////////////
	// Master clock: reset hold, idle clock timeout.
	always_ff @(posedge sys_clk_i) begin
		rst_link_r <= rst_i;
	end

	always_ff @(posedge sys_clk_i) begin
		sclk_s1_r <= sclk_i;
		sclk_s2_r <= sclk_s1_r;
		sclk_s3_r <= sclk_s2_r;
		sel_s1_r  <= regs_r[REG_CFG0_ADDR][CFG0_IDLE_SEL_BIT];
		sel_s2_r  <= sel_s1_r;
	end

	assign sclk_edge  = sclk_s2_r ^ sclk_s3_r;
	assign idle_limit = sel_s2_r ? TIMEOUT_SHORT_CYC : TIMEOUT_LONG_CYC;

	// The counter saturates so that one idle stretch aborts only once.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || sclk_edge) begin
			idle_cnt_r <= '0;
		end else if (idle_cnt_r != idle_limit) begin
			idle_cnt_r <= idle_cnt_r + 13'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		abort_r <= !rst_i && !sclk_edge && (idle_cnt_r == idle_limit - 13'h1); // see R24
	end

	// The serial clock stops outside frames, so the link side is cleared
	// asynchronously by select, timeout or the held reset.
	assign link_clr = cs_n_i | rst_link_r | abort_r; // see R25, R18

	////////////////////////////////////////////////////////////////////////
	// Crossings from the link side.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ev_s1_r   <= '0;
			ev_s2_r   <= '0;
			ev_s3_r   <= '0;
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
		end else begin
			ev_s1_r   <= ev_tog_r;
			ev_s2_r   <= ev_s1_r;
			ev_s3_r   <= ev_s2_r;
			busy_s1_r <= busy_r;
			busy_s2_r <= busy_s1_r;
		end
	end

	assign ev_pulse = ev_s2_r ^ ev_s3_r;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pulse_r  <= 1'b0;
			rstcmd_r <= 1'b0;
		end else begin
			pulse_r  <= ev_pulse[2]; // see R26
			rstcmd_r <= ev_pulse[3]; // see R16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result holding.
	assign clip_data = !result_overrange_i ? result_data_i :
		(result_data_i[23] ? FS_NEG : FS_POS); // see R22

	// An unread pending result is simply overwritten by the next one.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pend_data_r  <= '0;
			pend_flags_r <= '0;
			pend_v_r     <= 1'b0;
		end else if (result_valid_i) begin
			pend_data_r  <= clip_data;
			pend_flags_r <= {result_overrange_i, supply_low_i, channel_tag_i}; // see R22, R23
			pend_v_r     <= 1'b1;
		end else if (xfer) begin
			pend_v_r     <= 1'b0;
		end
	end

	// The held word only moves while no transfer is under way, which keeps
	// a command read whole; the busy level takes two master clocks to land.
	assign xfer = pend_v_r && !busy_s2_r; // see R12

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			hold_data_r  <= '0;
			hold_flags_r <= '0;
		end else if (xfer) begin
			hold_data_r  <= pend_data_r;
			hold_flags_r <= pend_flags_r;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fresh_r <= 1'b0;
		end else if (xfer) begin
			fresh_r <= 1'b1; // see R21
		end else if (ev_pulse[0] || ev_pulse[1]) begin
			fresh_r <= 1'b0; // see R21
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			taken_r <= 1'b0;
		end else if (xfer) begin
			taken_r <= 1'b0;
		end else if (ev_pulse[0]) begin
			taken_r <= 1'b1; // see R9
		end
	end

	// The strobe rises for one cycle before it falls, so every result moved to the held word
	// gives a falling edge even when the last one went unread.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			xfer_d_r  <= 1'b0;
			ready_n_r <= 1'b1;
		end else begin
			xfer_d_r <= xfer;
			if (xfer) begin
				ready_n_r <= 1'b1;
			end else if (xfer_d_r) begin
				ready_n_r <= 1'b0; // see R25
			end else if (ev_pulse[0] || ev_pulse[1]) begin
				ready_n_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link side, rising edge: command decode and register file.
	assign rx_byte    = {rx_sr_r, din_i}; // see R1
	assign direct_hit = (bit_cnt_r == DIRECT_BIT_IDX) &&
		(rx_byte[2:0] == DIRECT_LOW || rx_byte[2:0] == DIRECT_HIGH); // see R4
	assign cmd_done   = (state_r == ST_CMD) && (bit_cnt_r == BYTE_LAST_BIT);
	assign ptr_ok     = (ptr_r <= REG_LAST_ADDR);

	always_comb begin
		op_end = 1'b0;
		if (bit_cnt_r == BYTE_LAST_BIT) begin
			case (state_r)
				ST_CMD: begin
					op_end = !(rx_byte[7:5] == CMD_CH_READ || rx_byte[7:5] == CMD_REG_READ ||
						rx_byte[7:5] == CMD_REG_WRITE); // see R26, R28
				end
				ST_CH_READ: begin
					op_end = (ch_byte_r == CH_BYTE_LAST); // see R11
				end
				ST_REG_READ, ST_REG_WRITE: begin
					op_end = !multi_r || !ptr_ok || (ptr_r == REG_LAST_ADDR); // see R15
				end
				default: begin
					op_end = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sclk_i or posedge link_clr) begin
		if (link_clr) begin
			state_r   <= ST_CMD;
			bit_cnt_r <= '0;
			rx_sr_r   <= '0;
			multi_r   <= 1'b0;
			ptr_r     <= '0;
			ch_byte_r <= '0;
			busy_r    <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			rx_sr_r   <= rx_byte[6:0];
			busy_r    <= !op_end;
			case (state_r)
				ST_CMD: begin
					if (direct_hit) begin
						state_r <= ST_DIRECT; // see R4
					end else if (cmd_done) begin
						multi_r   <= rx_byte[CMD_MULTI_BIT];
						ptr_r     <= rx_byte[3:0];
						ch_byte_r <= '0;
						case (rx_byte[7:5])
							CMD_CH_READ:   state_r <= ST_CH_READ; // see R10
							CMD_REG_READ:  state_r <= ST_REG_READ; // see R13
							CMD_REG_WRITE: state_r <= ST_REG_WRITE; // see R14
							default:       state_r <= ST_CMD; // see R28
						endcase
					end
				end
				ST_DIRECT: begin
					state_r <= ST_DIRECT; // see R5
				end
				ST_CH_READ: begin
					if (bit_cnt_r == BYTE_LAST_BIT) begin
						if (op_end) begin
							state_r <= ST_CMD;
						end else begin
							ch_byte_r <= ch_byte_r + 2'h1;
						end
					end
				end
				ST_REG_READ, ST_REG_WRITE: begin
					if (bit_cnt_r == BYTE_LAST_BIT) begin
						if (op_end) begin
							state_r <= ST_CMD; // see R15
						end else begin
							ptr_r <= ptr_r + 4'h1; // see R15
						end
					end
				end
				default: begin
					state_r <= ST_CMD;
				end
			endcase
		end
	end

	// Registers survive select and timeout; only the reset pin and the reset
	// command restore them.
	always_ff @(posedge sclk_i or posedge rst_link_r) begin
		if (rst_link_r) begin
			regs_r   <= REG_DEFAULT;
			ev_tog_r <= '0;
		end else begin
			if (state_r == ST_CMD && direct_hit) begin
				ev_tog_r[0] <= !ev_tog_r[0];
			end
			if (cmd_done && rx_byte[7:5] == CMD_CH_READ) begin
				ev_tog_r[1] <= !ev_tog_r[1];
			end
			if (cmd_done && rx_byte[7:5] == CMD_PULSE) begin
				ev_tog_r[2] <= !ev_tog_r[2]; // see R26
			end
			if (cmd_done && rx_byte[7:5] == CMD_RESET) begin
				ev_tog_r[3] <= !ev_tog_r[3];
				regs_r      <= REG_DEFAULT; // see R16
			end else if (state_r == ST_REG_WRITE && bit_cnt_r == BYTE_LAST_BIT && ptr_ok) begin
				// Read-only bits keep their value, so the identification entry survives writes.
				regs_r[ptr_r] <= (regs_r[ptr_r] & ~REG_WMASK[ptr_r]) | (rx_byte & REG_WMASK[ptr_r]); // see R14
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link side, falling edge: output shifting.
	assign status_byte = {fresh_r, hold_flags_r}; // see R20
	assign direct_data = taken_r ? 24'h000000 : hold_data_r; // see R9
	assign direct_word = regs_r[REG_CFG0_ADDR][CFG0_STAT_BIT] ?
		{status_byte, direct_data} : {direct_data, 8'h00}; // see R19, R7
	assign ch_word     = {status_byte, hold_data_r}; // see R11, R27
	assign rd_byte     = ptr_ok ? regs_r[ptr_r] : 8'h00;

	// Past the last result bit zeros shift out; the host bounds the length.
	always_ff @(negedge sclk_i or posedge link_clr) begin
		if (link_clr) begin
			started_r <= 1'b0;
			fbit_r    <= '0;
			tx_sr_r   <= '0;
		end else begin
			started_r <= 1'b1;
			fbit_r    <= fbit_r + 3'h1;
			if (!started_r) begin
				tx_sr_r <= {direct_word[30:0], 1'b0}; // see R1, R6
			end else if (fbit_r == BYTE_LAST_BIT && state_r == ST_CH_READ && ch_byte_r == 2'h0) begin
				tx_sr_r <= ch_word; // see R11
			end else if (fbit_r == BYTE_LAST_BIT && state_r == ST_REG_READ) begin
				tx_sr_r <= {rd_byte, 24'h000000}; // see R13
			end else begin
				tx_sr_r <= {tx_sr_r[30:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign dout_o           = cs_n_i ? 1'b0 : (started_r ? tx_sr_r[31] : direct_word[31]); // see R6
	assign dout_oe_o        = !cs_n_i; // see R2
	assign result_ready_n_o = ready_n_r;
	assign pulse_convert_o  = pulse_r;
	assign reset_cmd_o      = rstcmd_r;
	assign idle_timeout_o   = abort_r;

endmodule : asc_serial_port

// *** tb/asc_host.sv ***
module asc_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [79:0] rx;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// Toggling select is also the recovery path for a locked interface.
	task sel(input logic on);
		#7.5 cs_n_o = !on;
		if (!on) din_o = ~din_o;
		#7.5;
	endtask : sel
	// The clock runs only inside shifts, so it stands still between frames.
	task shift(input int n, input logic [79:0] tx);
		for (int i = n - 1; i >= 0; i--) begin
			din_o = tx[i];
			#7.5 sclk_o = 1'b1;
			rx = {rx[78:0], dout_i};
			#7.5 sclk_o = 1'b0;
		end
	endtask : shift
endmodule : asc_host

// *** tb/asc_serial_port_chk.sv ***
module asc_serial_port_chk (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic result_valid_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic dout_o,
	input  wire logic dout_oe_o,
	input  wire logic result_ready_n_o,
	input  wire logic pulse_convert_o,
	input  wire logic reset_cmd_o,
	input  wire logic idle_timeout_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Margin below the short limit absorbs sampling jitter; the sync delay only lengthens the wait.
	localparam int IDLE_MIN = 250;
	logic        sclk_q_r, rdy_q_r, pend_r;
	logic [12:0] idle_cnt_r;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i) begin
		sclk_q_r <= sclk_i;
		if (rst_i || sclk_q_r != sclk_i) begin
			idle_cnt_r <= 13'h0;
		end else if (idle_cnt_r != 13'h1fff) begin
			idle_cnt_r <= idle_cnt_r + 13'h1;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		rdy_q_r <= result_ready_n_o;
		if (rst_i) begin
			pend_r <= 1'b0;
		end else if (result_valid_i) begin
			pend_r <= 1'b1;
		end else if (rdy_q_r && !result_ready_n_o) begin
			pend_r <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_tri; @(posedge sys_clk_i) disable iff (rst_i) cs_n_i |-> !dout_oe_o && !dout_o; endproperty
	property p_drive; @(posedge sclk_i) disable iff (rst_i) !cs_n_i |-> dout_oe_o; endproperty
	property p_pls; @(posedge sys_clk_i) disable iff (rst_i) pulse_convert_o |=> !pulse_convert_o; endproperty
	property p_rcmd; @(posedge sys_clk_i) disable iff (rst_i) reset_cmd_o |=> !reset_cmd_o; endproperty
	property p_excl; @(posedge sys_clk_i) disable iff (rst_i) !(pulse_convert_o && reset_cmd_o); endproperty
	property p_idle; @(posedge sys_clk_i) disable iff (rst_i) idle_timeout_o |-> idle_cnt_r >= IDLE_MIN; endproperty
	property p_idle1; @(posedge sys_clk_i) disable iff (rst_i) idle_timeout_o |=> !idle_timeout_o [*8]; endproperty
	property p_rdy; @(posedge sys_clk_i) disable iff (rst_i) $fell(result_ready_n_o) |-> pend_r; endproperty
	a_tri: assert property (p_tri) else $error("dout driven while deselected");
	a_drive: assert property (p_drive) else $error("dout not driven in frame");
	a_pls: assert property (p_pls) else $error("pulse convert too long");
	a_rcmd: assert property (p_rcmd) else $error("reset event too long");
	a_excl: assert property (p_excl) else $error("two command events at once");
	a_idle: assert property (p_idle) else $error("idle timeout too early");
	a_idle1: assert property (p_idle1) else $error("idle timeout repeated");
	a_rdy: assert property (p_rdy) else $error("ready without new result");
	c_pls: cover property (@(posedge sys_clk_i) pulse_convert_o);
	c_idle: cover property (@(posedge sys_clk_i) idle_timeout_o);
	c_rdy: cover property (@(posedge sys_clk_i) $fell(result_ready_n_o));
endmodule : asc_serial_port_chk

bind asc_serial_port asc_serial_port_chk i_chk (.sys_clk_i, .rst_i, .result_valid_i, .sclk_i, .cs_n_i, .dout_o,
	.dout_oe_o, .result_ready_n_o, .pulse_convert_o, .reset_cmd_o, .idle_timeout_o);

// *** tb/tb.sv ***
module tb
	import asc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk_i, rst_i, res_vld, res_over, sup_low;
	logic [23:0] res_dat, dat;
	logic [4:0]  res_tag;
	logic        sclk, cs_n, din, dout, dout_oe, rdy_n, pulse, rcmd, idle;
	logic [7:0]  st;
	logic [7:0]  regs [REG_COUNT];
	int          err_count, cmp_count, seed, cyc, n_pulse, n_rst, n_idle;
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	asc_serial_port i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .result_valid_i(res_vld),
		.result_data_i(res_dat), .result_overrange_i(res_over), .channel_tag_i(res_tag),
		.supply_low_i(sup_low), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout),
		.dout_oe_o(dout_oe), .result_ready_n_o(rdy_n), .pulse_convert_o(pulse),
		.reset_cmd_o(rcmd), .idle_timeout_o(idle));
	asc_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		n_pulse += pulse;
		n_rst += rcmd;
		n_idle += idle;
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			print_verdict();
		end
	end
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task print_verdict();
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	task xfer(input logic [7:0] c, input int n, input logic [79:0] d);
		i_host.sel(1'b1);
		i_host.shift(8, {72'h0, c});
		i_host.shift(n, d);
		i_host.sel(1'b0);
	endtask : xfer
	task wr(input logic [7:0] c, input int n, input logic [79:0] d);
		xfer(c, 8 * n, d);
		for (int a = 0; a < n; a++) begin
			int k;
			k = c[3:0] + a;
			if (k < REG_COUNT) regs[k] = regs[k] & ~REG_WMASK[k] | d[8 * (n - 1 - a) +: 8] & REG_WMASK[k];
		end
	endtask : wr
	task rd_all();
		xfer(8'h50, 80, 80'h0);
		for (int a = 0; a < REG_COUNT; a++) chk("reg", {24'h0, i_host.rx[79 - 8 * a -: 8]}, {24'h0, regs[a]});
	endtask : rd_all
	// The read follows the ready strobe so it ends well before the next result.
	task put(input logic over);
		@(negedge sys_clk_i);
		{res_dat, res_tag, sup_low} = 30'($random(seed));
		res_over = over;
		res_vld = 1'b1;
		@(negedge sys_clk_i);
		res_vld = 1'b0;
		dat = !over ? res_dat : res_dat[23] ? FS_NEG : FS_POS;
		st = {1'b1, over, sup_low, res_tag};
		for (int k = 0; k < 8 && rdy_n; k++) @(negedge sys_clk_i);
		chk("ready", {31'h0, rdy_n}, 32'h0);
	endtask : put
	task drd(input logic [7:0] f, input int n);
		xfer(f, n - 8, {80{f[0]}});
		chk("direct", n == 32 ? i_host.rx[31:0] : {8'h0, i_host.rx[23:0]}, n == 32 ? {st, dat} : {8'h0, dat});
		st[7] = 1'b0;
		dat = 24'h0;
	endtask : drd
	task crd();
		xfer(8'h30 | 8'($random(seed) & 15), 32, 80'h0);
		chk("cmd read", i_host.rx[31:0], {st, dat});
		st[7] = 1'b0;
	endtask : crd
	task cmd(input logic [7:0] c);
		xfer(c, 0, 80'h0);
		repeat (8) @(negedge sys_clk_i);
	endtask : cmd
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 54330;
		{res_vld, res_over, sup_low, res_dat, res_tag} = '0;
		foreach (regs[a]) regs[a] = REG_DEFAULT[a];
		rst_i = 1'b1;
		repeat (12) @(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		rd_all();
		wr(8'h72, 2, 80'($random(seed)));
		wr(8'h78, 2, 80'($random(seed)));
		rd_all();
		put(1'b0);
		drd(8'h00, 32);
		drd(8'hff, 32);
		put(1'($random(seed)));
		crd();
		crd();
		put(1'b1);
		crd();
		wr(8'h60, 1, 80'h08);
		put(1'b0);
		drd(8'hff, 24);
		drd(8'h00, 24);
		// Short timeout; a pulse command after a direct read must wait for it.
		wr(8'h60, 1, 80'h4a);
		put(1'b0);
		i_host.sel(1'b1);
		i_host.shift(40, 80'h80);
		chk("direct", i_host.rx[39:8], {st, dat});
		repeat (300) @(negedge sys_clk_i);
		chk("pulse ignored", n_pulse, 0);
		chk("timeout", n_idle, 1);
		i_host.shift(8, 80'h80);
		i_host.sel(1'b0);
		repeat (8) @(negedge sys_clk_i);
		chk("pulse", n_pulse, 1);
		cmd(8'ha5);
		chk("no-op", n_pulse + n_rst, 1);
		rd_all();
		cmd(8'hd7);
		cmd(8'h9f);
		chk("reset", n_rst, 1);
		chk("pulse", n_pulse, 2);
		foreach (regs[a]) regs[a] = REG_DEFAULT[a];
		rd_all();
		print_verdict();
	end
endmodule : tb
